// ==== core/atc_calib.sv ====
// Aux offset/gain calibration and temperature code conversion with an APB register file
//
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/100ps
`include "atc_defines.svh"

//
// Contract
// - Aux offset-corrected value is raw result shifted right two bits minus offset coefficient.
// - Offset-corrected value outside signed 17-bit range sets the offset overflow flag.
// - Multiply corrected value by gain coefficient, divide by 2^16, round to integer.
// - Aux result beyond signed 16 bits sets result overflow and saturates to 0x8000/0x7FFF.
// - Calibrated aux result is stored as a 16-bit value in its result register.
// - Temperature raw result becomes a signed 10-bit code, quarter degree per LSB.
// - Temperature code limited to 0x34C..0x1FF; outside sets result overflow and clamps.
// - Temperature conversion uses fixed reference, converter and preamplifier gain settings.
// - Raw conversion result is a signed 19-bit value, -262144 to +262143.
module atc_calib #(
    parameter int TEMP_SHIFT = 8,
    parameter logic signed [11:0] TEMP_OFFSET = 12'sh000
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire atc_pkg::atc_sample_type raw_conversion_result,
    input wire logic raw_valid,
    input wire logic temp_conv_active,
    output atc_pkg::atc_conv_cfg_type conv_cfg,
    output logic [15:0] aux_calibrated_result,
    output logic [9:0] temperature_code,
    output logic offset_overflow_flag,
    output logic result_overflow_flag,
    output logic aux_done,
    output logic temp_done,
    output logic irq
);

    // ==========================================================
    // Register state
    logic [16:0] aux_offset_coefficient_reg, aux_offset_coefficient_next;
    logic [16:0] aux_gain_coefficient_reg, aux_gain_coefficient_next;
    atc_pkg::atc_conv_cfg_type user_cfg_reg, user_cfg_next;
    atc_pkg::atc_conv_cfg_type conv_cfg_reg, conv_cfg_next;
    logic enable_reg, enable_next;
    logic [`ATC_EV_W-1:0] irq_enable_reg, irq_enable_next;
    logic [`ATC_EV_W-1:0] status_reg, status_next;
    logic [15:0] aux_result_reg, aux_result_next;
    logic [9:0] temp_code_reg, temp_code_next;
    logic aux_done_reg, aux_done_next;
    logic temp_done_reg, temp_done_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pslverr_reg, pslverr_next;

    // ==========================================================
    // Aux datapath signals
    logic signed [16:0] raw_div4;
    logic signed [17:0] offset_diff_wide;
    logic signed [16:0] offset_corrected_value;
    logic offset_ovf;
    logic signed [34:0] gain_product;
    logic signed [34:0] product_rounded;
    logic signed [34:0] product_scaled;
    logic result_ovf_aux;
    logic [15:0] aux_sat;

    // ==========================================================
    // Temperature datapath signals
    logic signed [18:0] temp_shifted;
    logic signed [19:0] temp_sum;
    logic signed [19:0] temp_min_wide;
    logic signed [19:0] temp_max_wide;
    logic result_ovf_temp;
    logic [9:0] temp_clamped;

    // ==========================================================
    // Bus phase decode
    logic setup_phase;
    logic write_access;
    logic sample_aux;
    logic sample_temp;
    logic [`ATC_EV_W-1:0] event_set;
    logic [`ATC_EV_W-1:0] event_clear;

    // APB phases: read data is latched in setup so it leaves a flop in access
    always_comb begin
        setup_phase = psel && !penable;
        write_access = psel && penable && pwrite;
    end

    // Samples only count while the path is enabled by software
    always_comb begin
        sample_aux = raw_valid && enable_reg &&
                     (raw_conversion_result.channel == atc_pkg::ATC_CH_AUX);
        sample_temp = raw_valid && enable_reg &&
                      (raw_conversion_result.channel == atc_pkg::ATC_CH_TEMP);
    end

    // ==========================================================
    // Aux offset correction
    // The 19-bit raw word is taken as signed over its full span
    always_comb begin
        raw_div4 = raw_conversion_result.data[18:`ATC_DROP_BITS];
        offset_diff_wide = {raw_div4[16], raw_div4} -
                           {aux_offset_coefficient_reg[16], aux_offset_coefficient_reg};
        offset_ovf = (offset_diff_wide[17] != offset_diff_wide[16]);
        offset_corrected_value = offset_diff_wide[16:0];
    end

    // ==========================================================
    // Aux gain scaling; gain is unsigned, so a zero sign bit is prepended
    // Negative products add one less than half so halves move away from zero
    always_comb begin
        gain_product = offset_corrected_value *
                       $signed({1'b0, aux_gain_coefficient_reg});
        product_rounded = gain_product + (gain_product[34] ? `ATC_ROUND_NEG
                                                           : `ATC_ROUND_POS);
        product_scaled = product_rounded >>> `ATC_GAIN_SHIFT;
    end

    // Saturation: anything whose upper bits are not a sign copy is out of range
    always_comb begin
        result_ovf_aux = !((&product_scaled[34:15]) || !(|product_scaled[34:15]));
        if (!result_ovf_aux) begin
            aux_sat = product_scaled[15:0];
        end else if (product_scaled[34]) begin
            aux_sat = `ATC_AUX_MIN;
        end else begin
            aux_sat = `ATC_AUX_MAX;
        end
    end

    // ==========================================================
    // Temperature conversion; shift and offset set the quarter-degree scale
    always_comb begin
        temp_shifted = $signed(raw_conversion_result.data) >>> TEMP_SHIFT;
        temp_sum = {temp_shifted[18], temp_shifted} +
                   20'(TEMP_OFFSET);
        temp_min_wide = $signed({{10{1'b1}}, `ATC_TEMP_MIN});
        temp_max_wide = $signed({10'h000, `ATC_TEMP_MAX});
        result_ovf_temp = 1'b0;
        if (temp_sum < temp_min_wide) begin
            temp_clamped = `ATC_TEMP_MIN;
            result_ovf_temp = 1'b1;
        end else if (temp_sum > temp_max_wide) begin
            temp_clamped = `ATC_TEMP_MAX;
            result_ovf_temp = 1'b1;
        end else begin
            temp_clamped = temp_sum[9:0];
        end
    end

    // ==========================================================
    // Result registers; an offset overflow still stores the scaled value,
    // flagged as untrustworthy rather than silently dropped
    always_comb begin
        aux_result_next = aux_result_reg;
        temp_code_next = temp_code_reg;
        aux_done_next = sample_aux;
        temp_done_next = sample_temp;
        if (sample_aux) begin
            aux_result_next = aux_sat;
        end
        if (sample_temp) begin
            temp_code_next = temp_clamped;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            aux_result_reg <= 16'h0000;
            temp_code_reg <= 10'h000;
            aux_done_reg <= 1'b0;
            temp_done_reg <= 1'b0;
        end else begin
            aux_result_reg <= aux_result_next;
            temp_code_reg <= temp_code_next;
            aux_done_reg <= aux_done_next;
            temp_done_reg <= temp_done_next;
        end
    end

    // ==========================================================
    // Converter settings: fixed values override user fields during temperature
    // conversion; registered so the front end never sees a decode glitch
    always_comb begin
        if (temp_conv_active) begin
            conv_cfg_next.reference_select = `ATC_FIX_REF_SELECT;
            conv_cfg_next.adc_gain = `ATC_FIX_ADC_GAIN;
            conv_cfg_next.pre_gain = `ATC_FIX_PRE_GAIN;
            conv_cfg_next.pre_amp_enable = `ATC_FIX_PRE_AMP_EN;
        end else begin
            conv_cfg_next = user_cfg_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            conv_cfg_reg <= atc_pkg::atc_conv_cfg_type'(`ATC_RST_CONV_CFG);
        end else begin
            conv_cfg_reg <= conv_cfg_next;
        end
    end

    // ==========================================================
    // Sticky event status; a set in the same cycle as a clear wins
    always_comb begin
        event_set = '0;
        event_set[`ATC_EV_AUX_DONE] = sample_aux;
        event_set[`ATC_EV_TEMP_DONE] = sample_temp;
        event_set[`ATC_EV_OFFSET_OVF] = sample_aux && offset_ovf;
        event_set[`ATC_EV_RESULT_OVF] = (sample_aux && result_ovf_aux) ||
                                         (sample_temp && result_ovf_temp);
        event_clear = '0;
        if (write_access && paddr == `ATC_OFF_IRQ_CLEAR) begin
            event_clear = pwdata[`ATC_EV_W-1:0];
        end
        status_next = (status_reg & ~event_clear) | event_set;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            status_reg <= '0;
        end else begin
            status_reg <= status_next;
        end
    end

    // ==========================================================
    // Writable registers; address decode as an if chain
    always_comb begin
        aux_offset_coefficient_next = aux_offset_coefficient_reg;
        aux_gain_coefficient_next = aux_gain_coefficient_reg;
        user_cfg_next = user_cfg_reg;
        enable_next = enable_reg;
        irq_enable_next = irq_enable_reg;
        if (write_access) begin
            if (paddr == `ATC_OFF_AUX_OFFSET) begin
                aux_offset_coefficient_next = pwdata[16:0];
            end else if (paddr == `ATC_OFF_AUX_GAIN) begin
                aux_gain_coefficient_next = pwdata[16:0];
            end else if (paddr == `ATC_OFF_CONV_CFG) begin
                user_cfg_next = atc_pkg::atc_conv_cfg_type'(pwdata[5:0]);
            end else if (paddr == `ATC_OFF_IRQ_ENABLE) begin
                irq_enable_next = pwdata[`ATC_EV_W-1:0];
            end else if (paddr == `ATC_OFF_CONTROL) begin
                enable_next = pwdata[`ATC_CTRL_ENABLE];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            aux_offset_coefficient_reg <= `ATC_RST_AUX_OFFSET;
            aux_gain_coefficient_reg <= `ATC_RST_AUX_GAIN;
            user_cfg_reg <= atc_pkg::atc_conv_cfg_type'(`ATC_RST_CONV_CFG);
            enable_reg <= `ATC_RST_CONTROL;
            irq_enable_reg <= `ATC_RST_IRQ_ENABLE;
        end else begin
            aux_offset_coefficient_reg <= aux_offset_coefficient_next;
            aux_gain_coefficient_reg <= aux_gain_coefficient_next;
            user_cfg_reg <= user_cfg_next;
            enable_reg <= enable_next;
            irq_enable_reg <= irq_enable_next;
        end
    end

    // ==========================================================
    // Read mux, captured in the setup cycle; unmapped offsets answer with
    // zero data and an error; the clear register reads as zero
    always_comb begin
        prdata_next = prdata_reg;
        pslverr_next = pslverr_reg;
        if (setup_phase) begin
            prdata_next = 32'h0000_0000;
            pslverr_next = 1'b0;
            if (paddr == `ATC_OFF_AUX_OFFSET) begin
                prdata_next[16:0] = aux_offset_coefficient_reg;
            end else if (paddr == `ATC_OFF_AUX_GAIN) begin
                prdata_next[16:0] = aux_gain_coefficient_reg;
            end else if (paddr == `ATC_OFF_AUX_RESULT) begin
                prdata_next[15:0] = aux_result_reg;
            end else if (paddr == `ATC_OFF_TEMP_CODE) begin
                prdata_next[9:0] = temp_code_reg;
            end else if (paddr == `ATC_OFF_CONV_CFG) begin
                prdata_next[5:0] = user_cfg_reg;
            end else if (paddr == `ATC_OFF_IRQ_STATUS) begin
                prdata_next[`ATC_EV_W-1:0] = status_reg;
            end else if (paddr == `ATC_OFF_IRQ_CLEAR) begin
                prdata_next = 32'h0000_0000;
            end else if (paddr == `ATC_OFF_IRQ_ENABLE) begin
                prdata_next[`ATC_EV_W-1:0] = irq_enable_reg;
            end else if (paddr == `ATC_OFF_CONTROL) begin
                prdata_next[`ATC_CTRL_ENABLE] = enable_reg;
            end else begin
                pslverr_next = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else begin
            prdata_reg <= prdata_next;
            pslverr_reg <= pslverr_next;
        end
    end

    // ==========================================================
    // Outputs; every access completes in its first access cycle
    assign pready = 1'b1;
    assign prdata = prdata_reg;
    assign pslverr = pslverr_reg;
    assign conv_cfg = conv_cfg_reg;
    assign aux_calibrated_result = aux_result_reg;
    assign temperature_code = temp_code_reg;
    assign offset_overflow_flag = status_reg[`ATC_EV_OFFSET_OVF];
    assign result_overflow_flag = status_reg[`ATC_EV_RESULT_OVF];
    assign aux_done = aux_done_reg;
    assign temp_done = temp_done_reg;
    assign irq = |(status_reg & irq_enable_reg); // Level, not a pulse

endmodule : atc_calib

// ==== core/atc_defines.svh ====
// Register map, field positions, reset values and limits of the aux/temperature calibration path
`ifndef ATC_DEFINES_SVH
`define ATC_DEFINES_SVH

// ==========================================================
// Register byte offsets
`define ATC_OFF_AUX_OFFSET 8'h00
`define ATC_OFF_AUX_GAIN 8'h04
`define ATC_OFF_AUX_RESULT 8'h08
`define ATC_OFF_TEMP_CODE 8'h0C
`define ATC_OFF_CONV_CFG 8'h10
`define ATC_OFF_IRQ_STATUS 8'h14
`define ATC_OFF_IRQ_CLEAR 8'h18
`define ATC_OFF_IRQ_ENABLE 8'h1C
`define ATC_OFF_CONTROL 8'h20

// ==========================================================
// Status / enable / clear bit positions
`define ATC_EV_AUX_DONE 0
`define ATC_EV_TEMP_DONE 1
`define ATC_EV_OFFSET_OVF 2
`define ATC_EV_RESULT_OVF 3
`define ATC_EV_W 4

// Control bit positions
`define ATC_CTRL_ENABLE 0

// ==========================================================
// Reset values
`define ATC_RST_AUX_OFFSET 17'h00000
`define ATC_RST_AUX_GAIN 17'h10000
`define ATC_RST_CONV_CFG 6'h00
`define ATC_RST_CONTROL 1'h1
`define ATC_RST_IRQ_ENABLE 4'h0

// ==========================================================
// Arithmetic constants
`define ATC_DROP_BITS 2
`define ATC_GAIN_SHIFT 16
`define ATC_ROUND_POS 35'sh0000_8000
`define ATC_ROUND_NEG 35'sh0000_7FFF
`define ATC_AUX_MIN 16'h8000
`define ATC_AUX_MAX 16'h7FFF
`define ATC_TEMP_MIN 10'h34C
`define ATC_TEMP_MAX 10'h1FF

// Fixed converter settings used while the temperature channel converts
`define ATC_FIX_REF_SELECT 1'h0
`define ATC_FIX_ADC_GAIN 2'h0
`define ATC_FIX_PRE_GAIN 2'h0
`define ATC_FIX_PRE_AMP_EN 1'h0

`endif

// ==== core/atc_pkg.sv ====
// Types shared by the aux/temperature calibration path
package atc_pkg;

    // ==========================================================
    // Channel carried with each filter sample
    typedef enum logic {
        ATC_CH_AUX,
        ATC_CH_TEMP
    } atc_channel_type;

    // One decimation-filter output word
    typedef struct packed {
        atc_channel_type channel;
        logic [18:0] data;
    } atc_sample_type;

    // Converter settings handed to the analog front end
    typedef struct packed {
        logic pre_amp_enable;
        logic [1:0] pre_gain;
        logic [1:0] adc_gain;
        logic reference_select;
    } atc_conv_cfg_type;

endpackage : atc_pkg

// ==== dv/atc_calib_asserts.sv ====
// Port-level checker for the aux/temperature calibration path
`timescale 1ns/100ps
`include "atc_defines.svh"
module atc_calib_asserts (
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire atc_pkg::atc_sample_type raw_conversion_result,
    input wire logic raw_valid,
    input wire logic temp_conv_active,
    input wire atc_pkg::atc_conv_cfg_type conv_cfg,
    input wire logic [15:0] aux_calibrated_result,
    input wire logic [9:0] temperature_code,
    input wire logic offset_overflow_flag,
    input wire logic result_overflow_flag,
    input wire logic aux_done,
    input wire logic temp_done
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    // ==========================================================
    // Helpers
    // Host clear strobes; a clear is the only legal way a flag may drop
    logic clr_wr;
    logic clr_offset_flag;
    logic clr_result_flag;
    assign clr_wr = psel && penable && pwrite && paddr == `ATC_OFF_IRQ_CLEAR;
    assign clr_offset_flag = clr_wr && pwdata[`ATC_EV_OFFSET_OVF];
    assign clr_result_flag = clr_wr && pwdata[`ATC_EV_RESULT_OVF];

    // Overflow first seen together with a finished conversion
    sequence s_aux_ovf;
        aux_done && $rose(result_overflow_flag);
    endsequence
    sequence s_temp_ovf;
        temp_done && $rose(result_overflow_flag);
    endsequence

    // ==========================================================
    // Properties
    property p_aux_cause;
        aux_done |-> $past(raw_valid) &&
            $past(raw_conversion_result.channel) == atc_pkg::ATC_CH_AUX;
    endproperty
    a_aux_cause: assert property (p_aux_cause) else $error("aux done without aux sample");
    property p_temp_cause;
        temp_done |-> $past(raw_valid) &&
            $past(raw_conversion_result.channel) == atc_pkg::ATC_CH_TEMP;
    endproperty
    a_temp_cause: assert property (p_temp_cause) else $error("temp done without sample");
    property p_aux_sat;
        s_aux_ovf |-> aux_calibrated_result inside {16'h8000, 16'h7FFF};
    endproperty
    a_aux_sat: assert property (p_aux_sat) else $error("aux overflow not saturated");
    property p_temp_clamp;
        s_temp_ovf |-> temperature_code inside {10'h34C, 10'h1FF};
    endproperty
    a_temp_clamp: assert property (p_temp_clamp) else $error("temp overflow not clamped");
    property p_temp_range;
        !(temperature_code inside {[10'h200 : 10'h34B]});
    endproperty
    a_temp_range: assert property (p_temp_range) else $error("temp code out of range");
    property p_offset_src;
        $rose(offset_overflow_flag) |-> aux_done;
    endproperty
    a_offset_src: assert property (p_offset_src) else $error("offset flag without aux");
    property p_result_src;
        $rose(result_overflow_flag) |-> aux_done || temp_done;
    endproperty
    a_result_src: assert property (p_result_src) else $error("result flag without sample");
    property p_offset_hold;
        offset_overflow_flag && !clr_offset_flag |=> offset_overflow_flag;
    endproperty
    a_offset_hold: assert property (p_offset_hold) else $error("offset flag dropped");
    property p_result_hold;
        result_overflow_flag && !clr_result_flag |=> result_overflow_flag;
    endproperty
    a_result_hold: assert property (p_result_hold) else $error("result flag dropped");
    property p_fixed_cfg;
        temp_conv_active |=> conv_cfg == 6'h00;
    endproperty
    a_fixed_cfg: assert property (p_fixed_cfg) else $error("user settings during temp");
endmodule : atc_calib_asserts

bind atc_calib atc_calib_asserts u_atc_calib_asserts (
    .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .raw_conversion_result(raw_conversion_result),
    .raw_valid(raw_valid), .temp_conv_active(temp_conv_active), .conv_cfg(conv_cfg),
    .aux_calibrated_result(aux_calibrated_result), .temperature_code(temperature_code),
    .offset_overflow_flag(offset_overflow_flag), .result_overflow_flag(result_overflow_flag),
    .aux_done(aux_done), .temp_done(temp_done)
);

// ==== dv/testbench.sv ====
// Self-checking bench for the aux/temperature calibration path
`timescale 1ns/100ps
`include "atc_defines.svh"
module testbench;
    // ==========================================================
    // Signals
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    atc_pkg::atc_sample_type raw_conversion_result = 20'h00000;
    logic raw_valid = 1'b0;
    logic temp_conv_active = 1'b0;
    atc_pkg::atc_conv_cfg_type conv_cfg;
    logic [15:0] aux_calibrated_result;
    logic [9:0] temperature_code;
    logic offset_overflow_flag, result_overflow_flag, aux_done, temp_done, irq;
    int errors = 0;
    int check_count = 0;
    logic [31:0] rd;
    logic er;

    // Cases: channel, raw, offset, gain, expected result, {offset ovf, result ovf}
    typedef struct {
        logic ch;
        logic [18:0] d;
        logic [16:0] o;
        logic [16:0] g;
        logic [15:0] r;
        logic [1:0] f;
    } atc_row_type;
    atc_row_type rows[12] = '{
        '{1'b0, 19'h00400, 17'h00000, 17'h10000, 16'h0100, 2'h0},
        '{1'b0, 19'h003FF, 17'h00004, 17'h08000, 16'h007E, 2'h0},
        '{1'b0, 19'h7FC14, 17'h00000, 17'h08000, 16'hFF82, 2'h0},
        '{1'b0, 19'h3FFFF, 17'h1FFFF, 17'h10000, 16'h8000, 2'h3},
        '{1'b0, 19'h20000, 17'h00000, 17'h10000, 16'h7FFF, 2'h1},
        '{1'b0, 19'h60000, 17'h00000, 17'h10000, 16'h8000, 2'h0},
        '{1'b0, 19'h00400, 17'h00000, 17'h1FFFF, 16'h0200, 2'h0},
        '{1'b1, 19'h01000, 17'h00000, 17'h10000, 16'h0010, 2'h0},
        '{1'b1, 19'h1FF00, 17'h00000, 17'h10000, 16'h01FF, 2'h0},
        '{1'b1, 19'h20000, 17'h00000, 17'h10000, 16'h01FF, 2'h1},
        '{1'b1, 19'h74C00, 17'h00000, 17'h10000, 16'h034C, 2'h0},
        '{1'b1, 19'h74B00, 17'h00000, 17'h10000, 16'h034C, 2'h1}
    };

    atc_calib #(.TEMP_SHIFT(8), .TEMP_OFFSET(12'sh000)) u_atc_calib (
        .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .raw_conversion_result(raw_conversion_result), .raw_valid(raw_valid),
        .temp_conv_active(temp_conv_active), .conv_cfg(conv_cfg),
        .aux_calibrated_result(aux_calibrated_result), .temperature_code(temperature_code),
        .offset_overflow_flag(offset_overflow_flag), .result_overflow_flag(result_overflow_flag),
        .aux_done(aux_done), .temp_done(temp_done), .irq(irq)
    );

    // 125 MHz clock
    initial begin
        forever #4 clk = ~clk;
    end

    // ==========================================================
    // Tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic test_done;
        $display("checks=%0d errors=%0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done

    // One APB transfer; the wait is bounded since a stuck slave must not hang the run
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            errors++;
            test_done();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask : apb

    // One filter sample; results are looked at in the cycle after it is taken
    task automatic send(input logic ch, input logic [18:0] d);
        @(posedge clk);
        raw_valid <= 1'b1;
        raw_conversion_result <= {ch, d};
        @(posedge clk);
        raw_valid <= 1'b0;
        #1;
    endtask : send

    // ==========================================================
    // Main sequence
    initial begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        foreach (rows[i]) begin
            apb(1'b1, `ATC_OFF_IRQ_CLEAR, 32'h0000000F);
            apb(1'b1, `ATC_OFF_AUX_OFFSET, {15'h0000, rows[i].o});
            apb(1'b1, `ATC_OFF_AUX_GAIN, {15'h0000, rows[i].g});
            send(rows[i].ch, rows[i].d);
            chk({aux_done, temp_done}, rows[i].ch ? 2'h1 : 2'h2);
            rd = rows[i].ch ? {22'h0, temperature_code} : {16'h0, aux_calibrated_result};
            chk(rd, {16'h0000, rows[i].r});
            chk({offset_overflow_flag, result_overflow_flag}, rows[i].f);
            apb(1'b0, rows[i].ch ? `ATC_OFF_TEMP_CODE : `ATC_OFF_AUX_RESULT, 32'h0);
            chk(rd, {16'h0000, rows[i].r});
        end
        // Overflow stays set across a clean sample until the host clears it
        apb(1'b1, `ATC_OFF_IRQ_ENABLE, 32'h00000008);
        chk(irq, 1'b1);
        apb(1'b1, `ATC_OFF_AUX_OFFSET, 32'h0);
        apb(1'b1, `ATC_OFF_AUX_GAIN, 32'h00010000);
        send(1'b0, 19'h00400);
        chk({result_overflow_flag, aux_calibrated_result}, 17'h10100);
        apb(1'b0, `ATC_OFF_IRQ_STATUS, 32'h0);
        chk(rd, 32'h0000000B);
        apb(1'b1, `ATC_OFF_IRQ_CLEAR, 32'h00000008);
        chk({irq, result_overflow_flag}, 2'h0);
        // User converter settings give way to fixed ones during temperature
        apb(1'b1, `ATC_OFF_CONV_CFG, 32'h0000003F);
        @(posedge clk);
        temp_conv_active <= 1'b1;
        #1 chk(conv_cfg, 6'h3F);
        @(posedge clk);
        #1 chk(conv_cfg, 6'h00);
        @(posedge clk);
        temp_conv_active <= 1'b0;
        // The user field itself survives the override
        apb(1'b0, `ATC_OFF_CONV_CFG, 32'h0);
        chk(rd, 32'h0000003F);
        // Samples are ignored while the path is disabled
        apb(1'b1, `ATC_OFF_CONTROL, 32'h0);
        send(1'b0, 19'h20000);
        chk({aux_done, result_overflow_flag, aux_calibrated_result}, 18'h00100);
        // Unmapped address answers with an error and zero data
        apb(1'b0, 8'h24, 32'h0);
        chk({er, rd[30:0]}, 32'h80000000);
        // Mid-run reset restores register defaults
        @(posedge clk);
        srst <= 1'b1;
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        apb(1'b0, `ATC_OFF_AUX_GAIN, 32'h0);
        chk(rd, 32'h00010000);
        apb(1'b0, `ATC_OFF_CONTROL, 32'h0);
        chk(rd, 32'h00000001);
        chk({aux_calibrated_result, offset_overflow_flag, result_overflow_flag}, 18'h00000);
        test_done();
    end
endmodule : testbench
